// ==== include/output_volume_map.vh ====
// Register indices, field positions, reset values and timing for the output volume and driver register bank.
`ifndef OUTPUT_VOLUME_MAP_VH
`define OUTPUT_VOLUME_MAP_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_LEFT_HEADPHONE_VOLUME        6'h24
`define IDX_RIGHT_HEADPHONE_VOLUME       6'h25
`define IDX_LEFT_SPEAKER_VOLUME          6'h26
`define IDX_RIGHT_SPEAKER_VOLUME         6'h27
`define IDX_LEFT_HEADPHONE_DRIVER_CTRL   6'h28
`define IDX_RIGHT_HEADPHONE_DRIVER_CTRL  6'h29
`define IDX_LEFT_SPEAKER_DRIVER_CTRL     6'h2A
`define IDX_IRQ_STATUS                   6'h30
`define IDX_IRQ_MASK                     6'h31

// Volume register fields.
`define VOL_ROUTE_BIT                    7
`define VOL_CODE_ALL_ONES                7'h7F
`define VOL_RESET                        8'h7F

// Driver control register fields.
`define DRV_MUTE_BIT                     2
`define DRV_APPLIED_BIT                  0
`define HP_GAIN_MAX                      4'h9
`define LEFT_HEADPHONE_CTRL_RESET        8'h02
`define RIGHT_HEADPHONE_CTRL_RESET       8'h02
`define LEFT_SPEAKER_CTRL_RESET          8'h00

// Settling time of a new gain before it counts as applied.
`define CLK_PERIOD_NS                    10
`define APPLY_TIME_NS                    1000
`define APPLY_CYCLES                     ((`APPLY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// AXI4-Lite responses.
`define RESP_OKAY                        2'h0
`define RESP_SLVERR                      2'h2

`endif

// ==== rtl/output_volume_driver_regs.v ====
// Output path volume, route, mute and driver gain register bank behind an AXI4-Lite slave.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "output_volume_map.vh"

// Functional notes
// - Left headphone feed mutes: route 0, code ones
// - Right headphone feed mutes: route 0, code ones
// - Left speaker feed mutes: route 0, code ones
// - Right speaker feed mutes: route 0, code ones
// - Seven-bit code resets ones, route resets zero
// - Left headphone gain equals code, 0 to 9
// - Right headphone gain equals code, 0 to 9
// - Left headphone driver muted while bit zero
// - Right headphone driver muted while bit zero
// - Left headphone applied flag, read only, resets 0
// - Right headphone applied flag, read only, resets 0
// - Speaker stage gain 6/12/18/24 dB, resets 00
// - Left speaker driver muted while bit zero
// - Left speaker applied flag, read only
module output_volume_driver_regs #(
    parameter ADDR_WIDTH   = 8,              // Byte address width on the bus.
    parameter APPLY_CYCLES = `APPLY_CYCLES   // Settling cycles before a gain counts as applied.
) (
    input  wire                  aclk,
    input  wire                  aresetn,
    input  wire [ADDR_WIDTH-1:0] awaddr,
    input  wire [2:0]            awprot,
    input  wire                  awvalid,
    output reg                   awready,
    input  wire [31:0]           wdata,
    input  wire [3:0]            wstrb,
    input  wire                  wvalid,
    output reg                   wready,
    output reg  [1:0]            bresp,
    output reg                   bvalid,
    input  wire                  bready,
    input  wire [ADDR_WIDTH-1:0] araddr,
    input  wire [2:0]            arprot,
    input  wire                  arvalid,
    output reg                   arready,
    output reg  [31:0]           rdata,
    output reg  [1:0]            rresp,
    output reg                   rvalid,
    input  wire                  rready,
    output reg  [3:0]            feed_mute,          // Per path: left hp, right hp, left spk, right spk.
    output reg  [27:0]           attenuation_index,  // Seven bits per path, same order as feed_mute.
    output reg  [3:0]            left_headphone_driver_gain,
    output reg                   left_headphone_driver_mute,
    output reg  [3:0]            right_headphone_driver_gain,
    output reg                   right_headphone_driver_mute,
    output reg  [1:0]            left_speaker_driver_gain,
    output reg                   left_speaker_driver_mute,
    output reg                   irq
);

    // Stored volume registers, one byte per path.
    reg [7:0]            vol [0:3];
    // Stored driver control bits 7..1; bit 0 is the live applied flag.
    reg [7:1]            drv [0:2];
    // Applied flags and their settle counters, one per driver.
    reg [2:0]            applied;
    reg [11:0]           settle_cnt [0:2];
    // Sticky event bits and their mask.
    reg [2:0]            irq_status;
    reg [2:0]            irq_mask;
    // Write channel holding state.
    reg                  aw_held;
    reg                  w_held;
    reg [ADDR_WIDTH-1:0] awaddr_q;
    reg [7:0]            wbyte_q;
    reg                  wstrb0_q;
    // Combinational decode results and the registered settle event pulses.
    reg                  wr_go;
    reg                  wr_en;
    reg                  wr_hit;
    reg [5:0]            wr_idx;
    reg [2:0]            restart;
    reg [2:0]            settled;
    reg [5:0]            rd_idx;
    reg [7:0]            rd_byte;
    reg                  rd_hit;
    integer              k;

    // Reset images of the driver controls; bit 0 is the live flag, not stored.
    localparam [7:0]     LHP_CTRL_RST  = `LEFT_HEADPHONE_CTRL_RESET;
    localparam [7:0]     RHP_CTRL_RST  = `RIGHT_HEADPHONE_CTRL_RESET;
    localparam [7:0]     LSPK_CTRL_RST = `LEFT_SPEAKER_CTRL_RESET;

    // Write decode: finds the target and which drivers see a gain change.
    always @* begin
        wr_go   = aw_held & w_held & ~bvalid;
        wr_idx  = awaddr_q[7:2];
        wr_en   = wr_go & wstrb0_q;
        wr_hit  = 1'b1;
        restart = 3'h0;
        // A write without strobe never restarts a counter, as wr_en carries it.
        case (wr_idx)
            `IDX_LEFT_HEADPHONE_VOLUME: begin
                restart[0] = wr_en & (wbyte_q[6:0] != vol[0][6:0]);
            end
            `IDX_RIGHT_HEADPHONE_VOLUME: begin
                restart[1] = wr_en & (wbyte_q[6:0] != vol[1][6:0]);
            end
            `IDX_LEFT_SPEAKER_VOLUME: begin
                restart[2] = wr_en & (wbyte_q[6:0] != vol[2][6:0]);
            end
            `IDX_RIGHT_SPEAKER_VOLUME: begin
                // No driver of this bank sits behind this feed.
                restart = 3'h0;
            end
            `IDX_LEFT_HEADPHONE_DRIVER_CTRL: begin
                restart[0] = wr_en & (wbyte_q[6:3] != drv[0][6:3]);
            end
            `IDX_RIGHT_HEADPHONE_DRIVER_CTRL: begin
                restart[1] = wr_en & (wbyte_q[6:3] != drv[1][6:3]);
            end
            `IDX_LEFT_SPEAKER_DRIVER_CTRL: begin
                restart[2] = wr_en & (wbyte_q[4:3] != drv[2][4:3]);
            end
            `IDX_IRQ_STATUS, `IDX_IRQ_MASK: begin
                // Interrupt registers carry no gain.
                restart = 3'h0;
            end
            default: begin
                // Unmapped index: error answer, nothing stored.
                wr_hit = 1'b0;
            end
        endcase
    end

    // Write address and data are taken in either order; the response waits for both.
    always @(posedge aclk) begin
        if (!aresetn) begin
            // Ready rises one edge after release.
            awready  <= 1'b0;
            wready   <= 1'b0;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            awaddr_q <= {ADDR_WIDTH{1'b0}};
            wbyte_q  <= 8'h00;
            wstrb0_q <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= `RESP_OKAY;
        end else begin
            // Ready is raised only while idle so that one write at most is under way.
            if (!awready && !aw_held && !bvalid) begin
                awready <= 1'b1;
            end else if (awready && awvalid) begin
                awready  <= 1'b0;
                aw_held  <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (!wready && !w_held && !bvalid) begin
                wready <= 1'b1;
            end else if (wready && wvalid) begin
                wready   <= 1'b0;
                w_held   <= 1'b1;
                wbyte_q  <= wdata[7:0];
                wstrb0_q <= wstrb[0];
            end
            // Both halves held: store and answer at one edge.
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid && bready) begin
                // The answer stood until the master took it.
                bvalid <= 1'b0;
            end
        end
    end

    // Register storage; only byte lane 0 carries data, upper lanes are ignored.
    always @(posedge aclk) begin
        if (!aresetn) begin
            // Volumes come up unrouted at the quietest code, so every feed is muted.
            for (k = 0; k < 4; k = k + 1) begin
                vol[k] <= `VOL_RESET;
            end
            drv[0]   <= LHP_CTRL_RST[7:1];
            drv[1]   <= RHP_CTRL_RST[7:1];
            drv[2]   <= LSPK_CTRL_RST[7:1];
            irq_mask <= 3'h0;
        end else if (wr_en) begin
            // Reserved bits of the volume and driver registers are stored as written; keeping them at their reset value is software's duty.
            case (wr_idx)
                `IDX_LEFT_HEADPHONE_VOLUME: begin
                    vol[0] <= wbyte_q;
                end
                `IDX_RIGHT_HEADPHONE_VOLUME: begin
                    vol[1] <= wbyte_q;
                end
                `IDX_LEFT_SPEAKER_VOLUME: begin
                    vol[2] <= wbyte_q;
                end
                `IDX_RIGHT_SPEAKER_VOLUME: begin
                    vol[3] <= wbyte_q;
                end
                `IDX_LEFT_HEADPHONE_DRIVER_CTRL: begin
                    drv[0] <= wbyte_q[7:1];
                end
                `IDX_RIGHT_HEADPHONE_DRIVER_CTRL: begin
                    drv[1] <= wbyte_q[7:1];
                end
                `IDX_LEFT_SPEAKER_DRIVER_CTRL: begin
                    drv[2] <= wbyte_q[7:1];
                end
                `IDX_IRQ_MASK: begin
                    irq_mask <= wbyte_q[2:0];
                end
                default: begin
                    // Status is cleared in its own process.
                    irq_mask <= irq_mask;
                end
            endcase
        end
    end

    // One settle counter per driver; a new gain restarts it and holds the flag low meanwhile.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : settle
            always @(posedge aclk) begin
                if (!aresetn) begin
                    // The reset gains are settled in as well, so the flag rises after one settle time.
                    settle_cnt[g] <= APPLY_CYCLES[11:0];
                    applied[g]    <= 1'b0;
                    settled[g]    <= 1'b0;
                end else if (restart[g]) begin
                    settle_cnt[g] <= APPLY_CYCLES[11:0];
                    applied[g]    <= 1'b0;
                    settled[g]    <= 1'b0;
                end else if (settle_cnt[g] != 12'h000) begin
                    // The flag and the event rise on the last step.
                    settle_cnt[g] <= settle_cnt[g] - 12'h001;
                    applied[g]    <= (settle_cnt[g] == 12'h001);
                    settled[g]    <= (settle_cnt[g] == 12'h001);
                end else begin
                    // The event is a one-cycle pulse.
                    settled[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Sticky event bits: a settle event in the same cycle as its clear keeps the bit set.
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 3'h0;
            irq        <= 1'b0;
        end else begin
            // A one clears its bit, a zero leaves it.
            if (wr_en && (wr_idx == `IDX_IRQ_STATUS)) begin
                irq_status <= (irq_status & ~wbyte_q[2:0]) | settled;
            end else begin
                // No clear this cycle: events only pile up.
                irq_status <= irq_status | settled;
            end
            // The level follows the status by one cycle, a cheap price for a flop-driven pin.
            irq <= |(irq_status & irq_mask);
        end
    end

    // Read decode; unmapped addresses answer with an error and zero data.
    always @* begin
        rd_idx  = araddr[7:2];
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        // Upper data lanes always read as zero.
        case (rd_idx)
            `IDX_LEFT_HEADPHONE_VOLUME: begin
                rd_byte = vol[0];
            end
            `IDX_RIGHT_HEADPHONE_VOLUME: begin
                rd_byte = vol[1];
            end
            `IDX_LEFT_SPEAKER_VOLUME: begin
                rd_byte = vol[2];
            end
            `IDX_RIGHT_SPEAKER_VOLUME: begin
                rd_byte = vol[3];
            end
            `IDX_LEFT_HEADPHONE_DRIVER_CTRL: begin
                rd_byte = {drv[0], applied[0]};
            end
            `IDX_RIGHT_HEADPHONE_DRIVER_CTRL: begin
                rd_byte = {drv[1], applied[1]};
            end
            `IDX_LEFT_SPEAKER_DRIVER_CTRL: begin
                rd_byte = {drv[2], applied[2]};
            end
            `IDX_IRQ_STATUS: begin
                rd_byte = {5'h00, irq_status};
            end
            `IDX_IRQ_MASK: begin
                rd_byte = {5'h00, irq_mask};
            end
            default: begin
                // Unmapped index: error with zero data.
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: one read under way, data captured when the address is taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            // Idle and silent in reset.
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `RESP_OKAY;
        end else begin
            if (!arready && !rvalid) begin
                arready <= 1'b1;
            end else if (arready && arvalid) begin
                // Captured here, so a later write cannot tear the answer.
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= {24'h000000, rd_byte};
                rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid && rready) begin
                // The answer stood until the master took it.
                rvalid <= 1'b0;
            end
        end
    end

    // Per path feed mute and table index toward the analog volume stage.
    generate
        for (g = 0; g < 4; g = g + 1) begin : path
            // Registered so each pin comes straight from a flop.
            always @(posedge aclk) begin
                if (!aresetn) begin
                    feed_mute[g]                 <= 1'b1;
                    attenuation_index[g*7 +: 7] <= `VOL_CODE_ALL_ONES;
                end else begin
                    // Route clear alone does not mute; the code must also be all ones.
                    feed_mute[g] <= ~vol[g][`VOL_ROUTE_BIT] & (vol[g][6:0] == `VOL_CODE_ALL_ONES);
                    // The nonlinear curve lives in a separate table indexed by this code.
                    attenuation_index[g*7 +: 7] <= vol[g][6:0];
                end
            end
        end
    endgenerate

    // Driver gains and mutes; reserved headphone codes are clamped so a bad write cannot overdrive.
    always @(posedge aclk) begin
        if (!aresetn) begin
            // Drivers come up muted at the lowest gain.
            left_headphone_driver_gain  <= 4'h0;
            right_headphone_driver_gain <= 4'h0;
            left_headphone_driver_mute  <= 1'b1;
            right_headphone_driver_mute <= 1'b1;
            left_speaker_driver_gain    <= 2'h0;
            left_speaker_driver_mute    <= 1'b1;
        end else begin
            // Reserved codes read back as written; only the pin is clamped.
            left_headphone_driver_gain  <= (drv[0][6:3] > `HP_GAIN_MAX) ? `HP_GAIN_MAX : drv[0][6:3];
            right_headphone_driver_gain <= (drv[1][6:3] > `HP_GAIN_MAX) ? `HP_GAIN_MAX : drv[1][6:3];
            left_headphone_driver_mute  <= ~drv[0][`DRV_MUTE_BIT];
            right_headphone_driver_mute <= ~drv[1][`DRV_MUTE_BIT];
            // Stage code 0 to 3 selects 6, 12, 18 or 24 dB.
            left_speaker_driver_gain    <= drv[2][4:3];
            left_speaker_driver_mute    <= ~drv[2][`DRV_MUTE_BIT];
        end
    end

endmodule // output_volume_driver_regs

// ==== tb/output_volume_driver_regs_monitor.sv ====
// Concurrent checks on the ports of the output volume driver register bank.
`timescale 1ns/1ps
module output_volume_driver_regs_monitor (
    input wire        aclk,
    input wire        aresetn,
    input wire        awready,
    input wire        arready,
    input wire        bvalid,
    input wire        bready,
    input wire        rvalid,
    input wire        rready,
    input wire [3:0]  feed_mute,
    input wire [27:0] attenuation_index,
    input wire [3:0]  left_headphone_driver_gain,
    input wire        left_headphone_driver_mute,
    input wire [3:0]  right_headphone_driver_gain,
    input wire        right_headphone_driver_mute,
    input wire [1:0]  left_speaker_driver_gain,
    input wire        left_speaker_driver_mute
);
    // One clock domain, so clock and reset are given once for every check.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Out of reset every path is silent: codes all ones, gains zero, drivers muted.
    AST_RESET_OUT: assert property ($rose(aresetn) |-> feed_mute == 4'hF && &attenuation_index
        && left_headphone_driver_gain == 4'h0 && right_headphone_driver_gain == 4'h0
        && left_speaker_driver_gain == 2'h0 && left_headphone_driver_mute
        && right_headphone_driver_mute && left_speaker_driver_mute) else $error("Outputs off reset values");
    // A muted feed always carries the all-ones code.
    AST_FEED_MUTE: assert property ((!feed_mute[0] || attenuation_index[6:0] == 7'h7F)
        && (!feed_mute[1] || attenuation_index[13:7] == 7'h7F) && (!feed_mute[2] || attenuation_index[20:14] == 7'h7F)
        && (!feed_mute[3] || attenuation_index[27:21] == 7'h7F)) else $error("Feed muted at other code");
    // Reserved gain codes never reach the headphone drivers.
    AST_LHP_GAIN: assert property (left_headphone_driver_gain <= 4'h9) else $error("Left gain above nine");
    AST_RHP_GAIN: assert property (right_headphone_driver_gain <= 4'h9) else $error("Right gain above nine");
    // Driver settings move only right after a write has been answered.
    AST_OUT_ON_WRITE: assert property ($changed({feed_mute, attenuation_index, left_headphone_driver_gain,
        left_headphone_driver_mute, right_headphone_driver_gain, right_headphone_driver_mute,
        left_speaker_driver_gain, left_speaker_driver_mute}) |-> $past(bvalid)) else $error("Output moved without write");
    // Responses stand until taken, and no new request is taken meanwhile.
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid) else $error("Write response dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid) else $error("Read response dropped");
    AST_AW_BUSY: assert property (bvalid |-> !awready) else $error("Address taken during response");
    AST_AR_BUSY: assert property (rvalid |-> !arready) else $error("Read address taken during response");
endmodule // output_volume_driver_regs_monitor

// ==== tb/output_volume_driver_regs_tb.sv ====
// Self-checking testbench of the output volume driver register bank.
`timescale 1ns/1ps
`include "output_volume_map.vh"
module output_volume_driver_regs_tb;
    localparam SETTLE = 40;                 // Short settling count keeps the run brief.
    reg         aclk, aresetn;              // Clock and active-low reset.
    reg  [7:0]  awaddr, araddr;             // Byte addresses.
    reg         awvalid, wvalid, bready, arvalid, rready;
    reg  [31:0] wdata;                      // Write data, byte zero meaningful.
    reg  [3:0]  wstrb;                      // Write strobes.
    wire        awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0]  bresp, rresp, lspk_gain;
    wire [31:0] rdata;
    wire [3:0]  feed_mute, lhp_gain, rhp_gain;
    wire [27:0] attenuation_index;
    wire        lhp_mute, rhp_mute, lspk_mute;
    reg  [7:0]  vol [0:3];                  // Expected volume registers.
    reg  [7:0]  ctl [0:2];                  // Expected driver controls, flag bit aside.
    reg  [31:0] got;                        // Data of the last read.
    reg  [7:0]  v, d;                       // Value written and random byte.
    integer     n_errors, n_tests, seed, k, j, g;

    output_volume_driver_regs #(.APPLY_CYCLES(SETTLE)) u_output_volume_driver_regs (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .feed_mute(feed_mute), .attenuation_index(attenuation_index),
        .left_headphone_driver_gain(lhp_gain), .left_headphone_driver_mute(lhp_mute),
        .right_headphone_driver_gain(rhp_gain), .right_headphone_driver_mute(rhp_mute),
        .left_speaker_driver_gain(lspk_gain), .left_speaker_driver_mute(lspk_mute), .irq(irq));

    // A feed is silent only when unrouted at the all-ones code.
    function mute_of(input [7:0] x);
        mute_of = !x[7] && x[6:0] == 7'h7F;
    endfunction
    // Reserved headphone codes are held at the top gain.
    function [3:0] clamp(input [3:0] x);
        clamp = (x > 4'h9) ? 4'h9 : x;
    endfunction
    task chk(input [31:0] a, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (a !== e) begin
                n_errors = n_errors + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, a, e);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("Counts: %0d tests, %0d errors", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    // Write with address and data offered together; each released when taken.
    // Ready for the answer rises after a random delay, so the slave must hold it.
    task wr(input [7:0] a, input [7:0] x, input [3:0] s, input [1:0] e);
        integer i, dly;
        reg     done;
        begin
            done = 0;
            dly = {$random(seed)} % 5;
            awaddr <= a; wdata <= {24'h0, x}; wstrb <= s; awvalid <= 1; wvalid <= 1;
            for (i = 0; i < 50 && !done; i = i + 1) begin
                @(posedge aclk);
                if (awready) awvalid <= 0;
                if (wready) wvalid <= 0;
                if (bvalid && bready) begin
                    bready <= 0;
                    done = 1;
                    chk(bresp, e);
                end else if (i == dly) bready <= 1;
            end
            if (!done) begin n_errors = n_errors + 1; give_verdict; end
        end
    endtask
    task rd(input [7:0] a, input [1:0] e);
        integer i, dly;
        reg     done;
        begin
            done = 0;
            dly = {$random(seed)} % 5;
            araddr <= a; arvalid <= 1;
            for (i = 0; i < 50 && !done; i = i + 1) begin
                @(posedge aclk);
                if (arready) arvalid <= 0;
                if (rvalid && rready) begin
                    rready <= 0;
                    done = 1;
                    got = rdata;
                    chk(rresp, e);
                end else if (i == dly) rready <= 1;
            end
            if (!done) begin n_errors = n_errors + 1; give_verdict; end
        end
    endtask
    // Compare every driver-side output with the expected registers.
    task chk_out;
        begin
            chk(feed_mute, {mute_of(vol[3]), mute_of(vol[2]), mute_of(vol[1]), mute_of(vol[0])});
            chk(attenuation_index, {vol[3][6:0], vol[2][6:0], vol[1][6:0], vol[0][6:0]});
            chk({lhp_gain, lhp_mute}, {clamp(ctl[0][6:3]), !ctl[0][2]});
            chk({rhp_gain, rhp_mute}, {clamp(ctl[1][6:3]), !ctl[1][2]});
            chk({lspk_gain, lspk_mute}, {ctl[2][4:3], !ctl[2][2]});
        end
    endtask

    // Free-running 100 MHz clock.
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors = n_errors + 1;
        give_verdict;
    end
    // Main sequence: reset values, interrupts, refusals, random traffic, settling flags.
    initial begin
        seed = 92857; n_errors = 0; n_tests = 0; aresetn = 0; awaddr = 0; araddr = 0; awvalid = 0;
        wvalid = 0; bready = 0; arvalid = 0; rready = 0; wdata = 0; wstrb = 0;
        for (k = 0; k < 4; k = k + 1) vol[k] = 8'h7F;
        ctl[0] = 8'h02; ctl[1] = 8'h02; ctl[2] = 8'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        // Driver controls are read first, before the reset settle has run out.
        for (k = 0; k < 7; k = k + 1) begin
            rd(8'(k < 3 ? 8'hA0 + 4 * k : 8'h84 + 4 * k), `RESP_OKAY);
            chk(got, k < 3 ? ctl[k] : vol[k - 3]);
        end
        chk_out;
        repeat (SETTLE + 20) @(posedge aclk);
        rd(8'hC0, `RESP_OKAY);
        chk(got, 32'h7);
        chk(irq, 0);
        wr(8'hC4, 8'h01, 4'h1, `RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(irq, 1);
        wr(8'hC0, 8'h07, 4'h1, `RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(irq, 0);
        // Unmapped places are refused; a write without strobe stores nothing.
        wr(8'h00, 8'hFF, 4'h1, `RESP_SLVERR);
        rd(8'h00, `RESP_SLVERR);
        chk(got, 0);
        wr(8'h90, 8'h00, 4'h0, `RESP_OKAY);
        rd(8'h90, `RESP_OKAY);
        chk(got, 8'h7F);
        // Random writes, with the all-ones code and a reserved gain among them.
        for (k = 0; k < 30; k = k + 1) begin
            j = (k == 5) ? 4 : {$random(seed)} % 7;
            d = $random(seed);
            g = (k == 5) ? 12 : {$random(seed)} % 10;
            if (j < 4) vol[j] = (k % 4 == 0) ? {d[7], 7'h7F} : d;
            else if (j < 6) ctl[j - 4] = {1'h0, g[3:0], d[2], 2'h2};
            else ctl[2] = {3'h0, d[4:3], d[2], 2'h0};
            v = (j < 4) ? vol[j] : ctl[j - 4];
            wr(8'(8'h90 + 4 * j), v, 4'hF, `RESP_OKAY);
            @(posedge aclk);
            chk_out;
            rd(8'(8'h90 + 4 * j), `RESP_OKAY);
            chk(got & 32'hFE, v & 8'hFE);
        end
        // A gain change drops the flag at once; it and the status return after settling.
        wr(8'hC0, 8'h07, 4'h1, `RESP_OKAY);
        for (k = 0; k < 3; k = k + 1) begin
            ctl[k] = ctl[k] ^ 8'h08;
            wr(8'(8'hA0 + 4 * k), ctl[k], 4'hF, `RESP_OKAY);
            rd(8'(8'hA0 + 4 * k), `RESP_OKAY);
            chk(got, ctl[k]);
        end
        repeat (SETTLE + 20) @(posedge aclk);
        rd(8'hC0, `RESP_OKAY);
        chk(got, 32'h7);
        chk(irq, 1);
        for (k = 0; k < 3; k = k + 1) begin
            rd(8'(8'hA0 + 4 * k), `RESP_OKAY);
            chk(got, ctl[k] | 8'h01);
        end
        give_verdict;
    end
endmodule // output_volume_driver_regs_tb

bind output_volume_driver_regs output_volume_driver_regs_monitor u_output_volume_driver_regs_monitor (
    .aclk, .aresetn, .awready, .arready, .bvalid, .bready, .rvalid, .rready, .feed_mute, .attenuation_index,
    .left_headphone_driver_gain, .left_headphone_driver_mute, .right_headphone_driver_gain,
    .right_headphone_driver_mute, .left_speaker_driver_gain, .left_speaker_driver_mute);
